// File: compact_timer_cfg.svh
`ifndef COMPACT_TIMER_CFG_SVH
`define COMPACT_TIMER_CFG_SVH

// Register byte offsets
`define OFS_CTRL0        12'h000
`define OFS_CTRL1        12'h004
`define OFS_COUNT        12'h008
`define OFS_FINE         12'h00C
`define OFS_FLAGS        12'h010

// Control zero fields
`define C0_HOLD          7
`define C0_CLK_HI        6
`define C0_CLK_LO        4
`define C0_RUN           3
`define C0_RP_HI         2
`define C0_RP_LO         0

// Control one fields
`define C1_MODE_HI       7
`define C1_MODE_LO       6
`define C1_IO_HI         5
`define C1_IO_LO         4
`define C1_OC            3
`define C1_POL           2
`define C1_DPX           1
`define C1_CCLR          0

// Flag bits
`define FLG_FINE         0
`define FLG_COARSE       1

`define CTRL_RST         8'h00
`define CNT_RST          10'h000
`define FULL_SPAN        11'h400
`define CNT_MAX          10'h3FF
`define DIV4_LAST        2'h3
`define COARSE_SHIFT     7

// Count clock selections
`define CKS_SYS_DIV4     3'h0
`define CKS_SYS          3'h1
`define CKS_HI_DIV16     3'h2
`define CKS_HI_DIV64     3'h3
`define CKS_TIMEBASE     3'h4
`define CKS_PIN_RISE     3'h6
`define CKS_PIN_FALL     3'h7
`define CKS_RESERVED     3'h5

// Pin actions
`define IO_NONE          2'h0
`define IO_LOW           2'h1
`define IO_HIGH          2'h2
`define IO_TOGGLE        2'h3

`endif

// File: compact_timer_pkg.sv
package compact_timer_pkg;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [9:0]  fine;
    logic [9:0]  cnt;
    logic [1:0]  flags;
    logic        pin;
    logic        run_prev;
    logic        ext_prev;
    logic [1:0]  div;
    logic [31:0] rdata;
    logic        out_a;
    logic        out_en;
  } state_t;

endpackage

// File: compact_timer_pwm.sv
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "compact_timer_cfg.svh"
// Functional notes
// - Coarse value compares counter bits 9..7; steps of 128, code 000 means 1024.
// - Coarse bits all zero: counter runs to maximum and overflows.
// - Clear select high clears on fine match; low on coarse match or overflow.
// - PWM mode ignores clear select; period register picked by swap bit clears.
// - Mode 00 compare output, 01 undefined, 10 PWM, 11 timer/counter.
// - Compare mode fine match: 00 keep, 01 low, 10 high, 11 toggle.
// - Compare mode pin changes only on fine matches and run rise, never on coarse.
// - Compare mode: pin loads initial level on run bit rising edge.
// - Action equal to present level leaves pin unchanged.
// - PWM actions: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - PWM: initial level bit is active polarity; no effect in timer mode.
// - Invert bit inverts the pin level; no effect in timer mode.
// - Swap 0: coarse period, fine duty; swap 1: fine period, coarse duty.
// - Compare modes: clear select low raises both flags; high only fine flag.
// - Fine clear with fine value zero: overflow at 3FF, no fine flag.
// - Timer mode counts and flags as compare mode but leaves pin undriven.
// - PWM mode raises each flag on its own comparator match.
// - PWM: period match clears counter, starting a new period.
// - Duty at or above period holds output active all period.
// - Run rising clears counter; run falling keeps the value and stops.
// - Hold bit freezes counter; counting resumes from that value.
// - Count clock select: sys/4, sys, high/16, high/64, time base, pin edges.
// - Ten-bit up counter; fine value compared against all counter bits.
module compact_timer_pwm
  import compact_timer_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        HIGH_DIV16_TICK_IN,
  input  wire logic        HIGH_DIV64_TICK_IN,
  input  wire logic        TIME_BASE_TICK_IN,
  input  wire logic        EXTERNAL_COUNT_IN,
  output logic             TIMER_OUTPUT_A_OUT,
  output logic             TIMER_OUTPUT_B_OUT,
  output logic             TIMER_OUTPUT_EN_OUT
);

  state_t      s_q;
  state_t      s_d;

  // Reset leaves compare mode, which drives the pins from the first cycle
  localparam state_t rst_state = '{out_en: 1'b1, default: '0};

  mode_t       mode;
  logic [1:0]  io;
  logic [2:0]  rp;
  logic [2:0]  cks;
  logic        run;
  logic        hold;
  logic        oc;
  logic        pol;
  logic        dpx;
  logic        cclr;
  logic        run_rise;
  logic        tick;
  logic        advance;
  logic [10:0] inc;
  logic [10:0] coarse_val;
  logic [10:0] fine_val;
  logic [10:0] period_val;
  logic [10:0] duty_val;
  logic        coarse_hit;
  logic        fine_hit;
  logic        overflow;
  logic        clr_cnt;
  logic        set_fine;
  logic        set_coarse;
  logic        pwm_act;
  logic        lvl;
  logic        setup_ph;
  logic        access_ph;
  logic        wr;
  logic        mapped;
  logic [2:0]  nxt_rp;
  logic [10:0] nxt_coarse;
  logic [10:0] nxt_fine;
  logic [10:0] nxt_period;
  logic [10:0] nxt_duty;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  always_comb begin
    mode = mode_t'(s_q.ctrl1[`C1_MODE_HI:`C1_MODE_LO]);
    io   = s_q.ctrl1[`C1_IO_HI:`C1_IO_LO];
    oc   = s_q.ctrl1[`C1_OC];
    pol  = s_q.ctrl1[`C1_POL];
    dpx  = s_q.ctrl1[`C1_DPX];
    cclr = s_q.ctrl1[`C1_CCLR];
    rp   = s_q.ctrl0[`C0_RP_HI:`C0_RP_LO];
    cks  = s_q.ctrl0[`C0_CLK_HI:`C0_CLK_LO];
    run  = s_q.ctrl0[`C0_RUN];
    hold = s_q.ctrl0[`C0_HOLD];
    run_rise = run && !s_q.run_prev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count clock; pin edges seen by comparing with the previous sample
  always_comb begin
    case (cks)
      `CKS_SYS_DIV4: tick = (s_q.div == `DIV4_LAST);
      `CKS_SYS:      tick = 1'b1;
      `CKS_HI_DIV16: tick = HIGH_DIV16_TICK_IN;
      `CKS_HI_DIV64: tick = HIGH_DIV64_TICK_IN;
      `CKS_TIMEBASE: tick = TIME_BASE_TICK_IN;
      `CKS_PIN_RISE: tick = EXTERNAL_COUNT_IN && !s_q.ext_prev;
      `CKS_PIN_FALL: tick = !EXTERNAL_COUNT_IN && s_q.ext_prev;
      default:       tick = 1'b0;
    endcase
    advance = run && !hold && !run_rise && tick;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators; zero codes stand for a full 1024-count span
  always_comb begin
    inc        = {1'b0, s_q.cnt} + 11'h001;
    coarse_val = (rp == 3'h0) ? `FULL_SPAN
                              : {1'b0, rp, 7'h00};
    fine_val   = (s_q.fine == 10'h000) ? `FULL_SPAN : {1'b0, s_q.fine};
    overflow   = (s_q.cnt == `CNT_MAX);
    coarse_hit = (inc == coarse_val);
    fine_hit   = (s_q.fine != 10'h000) && (inc == {1'b0, s_q.fine});
    period_val = dpx ? fine_val : coarse_val;
    duty_val   = dpx ? coarse_val : fine_val;
    if (mode == MODE_PWM) begin
      clr_cnt    = dpx ? (inc == fine_val) : coarse_hit;
      set_fine   = fine_hit;
      set_coarse = coarse_hit;
    end else if (cclr) begin
      clr_cnt    = fine_hit || overflow;
      set_fine   = fine_hit;
      set_coarse = 1'b0;
    end else begin
      clr_cnt    = coarse_hit;
      set_fine   = fine_hit;
      set_coarse = coarse_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: read data captured in setup, so access is always zero-wait
  always_comb begin
    setup_ph  = PSEL_IN && !PENABLE_IN;
    access_ph = PSEL_IN && PENABLE_IN;
    wr        = access_ph && PWRITE_IN;
    mapped    = (PADDR_IN == `OFS_CTRL0) || (PADDR_IN == `OFS_CTRL1) ||
                (PADDR_IN == `OFS_COUNT) || (PADDR_IN == `OFS_FINE)  ||
                (PADDR_IN == `OFS_FLAGS);
    PREADY_OUT  = 1'b1;
    PSLVERR_OUT = access_ph && !mapped;
    PRDATA_OUT  = s_q.rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    if (CLK_EN_IN) begin
      s_d.run_prev = run;
      s_d.ext_prev = EXTERNAL_COUNT_IN;
      s_d.div      = s_q.div + 2'h1;

      if (run_rise) begin
        s_d.cnt = `CNT_RST;
        if (mode == MODE_COMPARE) begin
          s_d.pin = oc;
        end
      end else if (advance) begin
        s_d.cnt = clr_cnt ? `CNT_RST : inc[9:0];
        if (mode == MODE_COMPARE && fine_hit) begin
          case (io)
            `IO_LOW:    s_d.pin = 1'b0;
            `IO_HIGH:   s_d.pin = 1'b1;
            `IO_TOGGLE: s_d.pin = !s_q.pin;
            default:    s_d.pin = s_q.pin;
          endcase
        end
      end

      // Writing one clears a flag, but a match in the same cycle wins
      if (wr && PADDR_IN == `OFS_FLAGS) begin
        s_d.flags = s_q.flags & ~PWDATA_IN[1:0];
      end
      if (advance && set_fine) begin
        s_d.flags[`FLG_FINE] = 1'b1;
      end
      if (advance && set_coarse) begin
        s_d.flags[`FLG_COARSE] = 1'b1;
      end

      if (wr) begin
        if (PADDR_IN == `OFS_CTRL0) begin
          s_d.ctrl0 = PWDATA_IN[7:0];
        end else if (PADDR_IN == `OFS_CTRL1) begin
          s_d.ctrl1 = PWDATA_IN[7:0];
        end else if (PADDR_IN == `OFS_FINE) begin
          s_d.fine = PWDATA_IN[9:0];
        end
      end

      if (setup_ph) begin
        if (PADDR_IN == `OFS_CTRL0) begin
          s_d.rdata = {24'h000000, s_q.ctrl0};
        end else if (PADDR_IN == `OFS_CTRL1) begin
          s_d.rdata = {24'h000000, s_q.ctrl1};
        end else if (PADDR_IN == `OFS_COUNT) begin
          s_d.rdata = {22'h000000, s_q.cnt};
        end else if (PADDR_IN == `OFS_FINE) begin
          s_d.rdata = {22'h000000, s_q.fine};
        end else if (PADDR_IN == `OFS_FLAGS) begin
          s_d.rdata = {30'h00000000, s_q.flags};
        end else begin
          s_d.rdata = 32'h00000000;
        end
      end
    end

    // Pin level follows the settled next state, so it never lags a cycle
    // Period and duty come from the next state too, so a register write
    // and the pin level it implies land on the same edge
    nxt_rp     = s_d.ctrl0[`C0_RP_HI:`C0_RP_LO];
    nxt_coarse = (nxt_rp == 3'h0) ? `FULL_SPAN : {1'b0, nxt_rp, 7'h00};
    nxt_fine   = (s_d.fine == 10'h000) ? `FULL_SPAN : {1'b0, s_d.fine};
    nxt_period = s_d.ctrl1[`C1_DPX] ? nxt_fine : nxt_coarse;
    nxt_duty   = s_d.ctrl1[`C1_DPX] ? nxt_coarse : nxt_fine;
    pwm_act = (nxt_duty >= nxt_period) ||
              ({1'b0, s_d.cnt} < nxt_duty);
    if (mode_t'(s_d.ctrl1[`C1_MODE_HI:`C1_MODE_LO]) == MODE_PWM) begin
      case (s_d.ctrl1[`C1_IO_HI:`C1_IO_LO])
        `IO_LOW:  lvl = s_d.ctrl1[`C1_OC];
        `IO_HIGH: lvl = pwm_act ? s_d.ctrl1[`C1_OC] : !s_d.ctrl1[`C1_OC];
        default:  lvl = !s_d.ctrl1[`C1_OC];
      endcase
    end else begin
      lvl = s_d.pin;
    end
    s_d.out_a  = lvl ^ s_d.ctrl1[`C1_POL];
    // Undefined mode also releases the pin; it cannot drive a known shape
    s_d.out_en = (s_d.ctrl1[`C1_MODE_HI:`C1_MODE_LO] == MODE_COMPARE) ||
                 (s_d.ctrl1[`C1_MODE_HI:`C1_MODE_LO] == MODE_PWM);
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      s_q <= rst_state;
    end else begin
      s_q <= s_d;
    end
  end

  assign TIMER_OUTPUT_A_OUT  = s_q.out_a;
  assign TIMER_OUTPUT_B_OUT  = !s_q.out_a;
  assign TIMER_OUTPUT_EN_OUT = s_q.out_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_step;
    CLK_EN_IN && advance && !(PSEL_IN && PENABLE_IN && PWRITE_IN);
  endsequence

  sequence s_cleared_fine;
    ##1 (s_q.cnt == `CNT_RST) && s_q.flags[`FLG_FINE];
  endsequence

  property p_run_rise_zero;
    CLK_EN_IN && run_rise |=> s_q.cnt == `CNT_RST;
  endproperty
  a_run_rise_zero: assert property (p_run_rise_zero)
    else $error("counter not zero after run rise");

  property p_hold_freeze;
    CLK_EN_IN && run && hold && !run_rise |=> $stable(s_q.cnt);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("counter moved while held");

  property p_fine_clear;
    s_step ##0 (mode == MODE_COMPARE && cclr && fine_hit) |-> s_cleared_fine;
  endproperty
  a_fine_clear: assert property (p_fine_clear)
    else $error("fine match did not clear and flag");

  property p_coarse_clear;
    s_step ##0 (mode != MODE_PWM && !cclr && coarse_hit)
      |=> (s_q.cnt == `CNT_RST) && s_q.flags[`FLG_COARSE];
  endproperty
  a_coarse_clear: assert property (p_coarse_clear)
    else $error("coarse match did not clear and flag");

  property p_no_coarse_flag;
    CLK_EN_IN && mode != MODE_PWM && cclr && !s_q.flags[`FLG_COARSE]
      |=> !s_q.flags[`FLG_COARSE];
  endproperty
  a_no_coarse_flag: assert property (p_no_coarse_flag)
    else $error("coarse flag raised with fine clear select");

  property p_fine_zero_wrap;
    s_step ##0 (mode != MODE_PWM && cclr && s_q.fine == 10'h000 &&
      s_q.cnt == `CNT_MAX && !s_q.flags[`FLG_FINE])
      |=> s_q.cnt == `CNT_RST && !s_q.flags[`FLG_FINE];
  endproperty
  a_fine_zero_wrap: assert property (p_fine_zero_wrap)
    else $error("fine zero did not overflow quietly");

  property p_timer_release;
    mode == MODE_TIMER |-> !TIMER_OUTPUT_EN_OUT;
  endproperty
  a_timer_release: assert property (p_timer_release)
    else $error("pin driven in timer mode");

  property p_full_duty;
    mode == MODE_PWM && io == `IO_HIGH && duty_val >= period_val
      |-> TIMER_OUTPUT_A_OUT == (oc ^ pol);
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty output not active");

  property p_pin_fine_only;
    CLK_EN_IN && mode == MODE_COMPARE && !run_rise && !(advance && fine_hit)
      |=> $stable(s_q.pin);
  endproperty
  a_pin_fine_only: assert property (p_pin_fine_only)
    else $error("pin changed without fine match");

  property p_pwm_period;
    s_step ##0 (mode == MODE_PWM && !dpx && coarse_hit) |=> s_q.cnt == `CNT_RST;
  endproperty
  a_pwm_period: assert property (p_pwm_period)
    else $error("pwm period match did not clear");

  // Flag set is checked on write cycles as well: a match must beat a clear
  property p_fine_flag_set;
    CLK_EN_IN && advance && set_fine |=> s_q.flags[`FLG_FINE];
  endproperty
  a_fine_flag_set: assert property (p_fine_flag_set)
    else $error("fine match did not raise its flag");

  property p_run_rise_level;
    CLK_EN_IN && run_rise && mode == MODE_COMPARE |=> s_q.pin == $past(oc);
  endproperty
  a_run_rise_level: assert property (p_run_rise_level)
    else $error("pin not loaded with initial level");

  property p_reserved_clock;
    CLK_EN_IN && cks == `CKS_RESERVED && !run_rise |=> $stable(s_q.cnt);
  endproperty
  a_reserved_clock: assert property (p_reserved_clock)
    else $error("counter moved on reserved clock select");

  property p_compare_invert;
    mode == MODE_COMPARE |-> TIMER_OUTPUT_A_OUT == (s_q.pin ^ pol);
  endproperty
  a_compare_invert: assert property (p_compare_invert)
    else $error("compare pin level not inverted as selected");

  property p_swap_period;
    s_step ##0 (mode == MODE_PWM && dpx && inc == fine_val) |=> s_q.cnt == `CNT_RST;
  endproperty
  a_swap_period: assert property (p_swap_period)
    else $error("fine period match did not clear in swap mode");

endmodule

// File: timer_pins_model.sv
`timescale 1ns/1ps
module timer_pins_model (
  input  wire logic        clk_in,
  input  wire logic        pin_a_in,
  input  wire logic        pin_b_in,
  output logic             ext_count_out,
  output logic      [15:0] high_cycles_out,
  output logic             pair_ok_out
);
  logic [1:0] div_q;

  initial begin
    div_q = 2'h0;
    ext_count_out = 1'b0;
    high_cycles_out = 16'h0000;
    pair_ok_out = 1'b1;
  end

  // Pin clock has an 8 cycle period, so both edges are seen in a fixed ratio
  always @(posedge clk_in) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) ext_count_out <= ~ext_count_out;
    if (pin_a_in === 1'b1) high_cycles_out <= high_cycles_out + 16'h0001;
    if (pin_b_in !== ~pin_a_in) pair_ok_out <= 1'b0;
  end
endmodule

// File: compact_timer_pwm_tb.sv
`timescale 1ns/1ps
`include "compact_timer_cfg.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module compact_timer_pwm_tb;
  logic        clk, nrst, en, psel, penable, pwrite, t16, t64, ttb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, errv, ext, pa, pb, poe, pair_ok;
  logic [15:0] hic, h0;
  logic [9:0]  c1;
  logic [7:0]  tk;
  int          n_fail, cmp_count;
  localparam logic [9:0]  CKX [8] = '{10'h080, 10'h200, 10'h020, 10'h008,
                                      10'h010, 10'h000, 10'h040, 10'h040};
  localparam logic [7:0]  PC1 [8] = '{8'hA8, 8'hA0, 8'hAC, 8'h88, 8'h98, 8'hAB, 8'hA8, 8'hAA};
  localparam logic [9:0]  PFN [8] = '{10'h020, 10'h020, 10'h020, 10'h020, 10'h020,
                                      10'h0C8, 10'h12C, 10'h064};
  localparam logic [15:0] PWN [8] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200,
                                      16'h0320, 16'h0200, 16'h0190};
  localparam logic [15:0] PHI [8] = '{16'h0080, 16'h0180, 16'h0180, 16'h0000, 16'h0200,
                                      16'h0200, 16'h0200, 16'h0190};
  localparam logic [1:0]  PFL [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h1};
  localparam logic [7:0]  CC1 [5] = '{8'h19, 8'h39, 8'h29, 8'h09, 8'h1D};
  localparam logic        CST [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic        CAF [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  compact_timer_pwm uut (.REF_CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(en), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .HIGH_DIV16_TICK_IN(t16), .HIGH_DIV64_TICK_IN(t64), .TIME_BASE_TICK_IN(ttb),
    .EXTERNAL_COUNT_IN(ext), .TIMER_OUTPUT_A_OUT(pa), .TIMER_OUTPUT_B_OUT(pb),
    .TIMER_OUTPUT_EN_OUT(poe));
  timer_pins_model pins (.clk_in(clk), .pin_a_in(pa), .pin_b_in(pb), .ext_count_out(ext),
    .high_cycles_out(hic), .pair_ok_out(pair_ok));

  ////////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // Tick sources are free running so the selected rate alone sets the count
  always @(posedge clk) begin
    tk <= tk + 8'h01;
    t16 <= (tk[3:0] == 4'hF);
    t64 <= (tk[5:0] == 6'h3F);
    ttb <= (tk[4:0] == 5'h1F);
  end

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5_000_000;
    n_fail++;
    give_verdict();
  end

  initial begin
    clk = 1'b0; nrst = 1'b0; en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; tk = 8'h00; t16 = 1'b0; t64 = 1'b0; ttb = 1'b0;
    n_fail = 0; cmp_count = 0;
    wt(4);
    nrst <= 1'b1;
    wt(1);
    `CHK("pin_a", 1'b0, pa)
    `CHK("pin_en", 1'b1, poe)
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, {i[9:0], 2'b00}, 32'h0);
      `CHK("reset_value", 32'h0, rdv)
    end
    apb(1'b1, 12'h014, 32'hFF);
    `CHK("unmapped_err", 1'b1, errv)
    apb(1'b1, `OFS_COUNT, 32'h155);
    apb(1'b1, `OFS_FINE, 32'hFFFFFFFF);
    apb(1'b0, `OFS_FINE, 32'h0);
    `CHK("fine_rw", 32'h3FF, rdv)
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("count_ro", 32'h0, rdv)
    // Coarse period 128 clears the counter, fine match at 200 never comes
    apb(1'b1, `OFS_CTRL1, 32'h38);
    apb(1'b1, `OFS_FINE, 32'h0C8);
    apb(1'b1, `OFS_CTRL0, 32'h19);
    wt(90);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK("flags_early", 32'h0, rdv)
    wt(60);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    `CHK("flags_coarse", 32'h2, rdv)
    `CHK("pin_no_coarse", 1'b1, pa)
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("count_wrap128", 3'h0, rdv[9:7])
    // Coarse zero lets the count pass 512, then hold and stop keep it
    apb(1'b1, `OFS_CTRL0, 32'h10);
    apb(1'b1, `OFS_CTRL1, 32'h00);
    apb(1'b1, `OFS_CTRL0, 32'h18);
    wt(600);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("overflow_run", 1'b1, rdv[9])
    apb(1'b1, `OFS_CTRL0, 32'h98);
    apb(1'b0, `OFS_COUNT, 32'h0);
    c1 = rdv[9:0];
    wt(50);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("hold_freeze", c1, rdv[9:0])
    apb(1'b1, `OFS_CTRL0, 32'h18);
    wt(10);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("hold_resume", 1'b1, rdv[9:0] > c1)
    apb(1'b1, `OFS_CTRL0, 32'h10);
    apb(1'b0, `OFS_COUNT, 32'h0);
    c1 = rdv[9:0];
    wt(50);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("stop_keep", c1, rdv[9:0])
    apb(1'b1, `OFS_CTRL0, 32'h18);
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("start_zero", 6'h00, rdv[9:4])
    // Clock enable low for 50 edges: only the three enabled edges count
    c1 = rdv[9:0];
    en <= 1'b0;
    wt(50);
    en <= 1'b1;
    apb(1'b0, `OFS_COUNT, 32'h0);
    `CHK("clk_en_freeze", 10'h003, rdv[9:0] - c1)
    // Fine clear: ten ticks with fine flag only, then fine zero wraps past 3FF quietly
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `OFS_CTRL0, 32'h11);
      apb(1'b1, `OFS_CTRL1, 32'h01);
      apb(1'b1, `OFS_FINE, k ? 32'h0 : 32'h00A);
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_CTRL0, 32'h19);
      wt(k ? 1100 : 300);
      apb(1'b0, `OFS_FLAGS, 32'h0);
      `CHK("fine_flags", k ? 32'h0 : 32'h1, rdv)
      apb(1'b0, `OFS_COUNT, 32'h0);
      `CHK("fine_clear", 1'b1, k ? rdv[9:5] == 5'h02 : rdv[9:0] < 10'h00A)
    end
    // Pin actions on fine match at 50, started from the initial level
    apb(1'b1, `OFS_FINE, 32'h032);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, `OFS_CTRL0, 32'h11);
      apb(1'b1, `OFS_CTRL1, {24'h0, CC1[k]});
      apb(1'b1, `OFS_CTRL0, 32'h19);
      wt(3);
      `CHK("pin_initial", CST[k], pa)
      wt(60);
      `CHK("pin_action", CAF[k], pa)
    end
    // Output enable and flags for each mode code
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `OFS_CTRL0, 32'h11);
      apb(1'b1, `OFS_CTRL1, {24'h0, m[1:0], 6'h00});
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_CTRL0, 32'h19);
      wt(150);
      `CHK("pin_en_mode", ~m[0], poe)
      apb(1'b0, `OFS_FLAGS, 32'h0);
      `CHK("mode_flags", 32'h3, rdv)
    end
    // Duty measured over whole periods is exact whatever the phase
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `OFS_CTRL0, 32'h11);
      apb(1'b1, `OFS_CTRL1, {24'h0, PC1[k]});
      apb(1'b1, `OFS_FINE, {22'h0, PFN[k]});
      apb(1'b1, `OFS_FLAGS, 32'h3);
      apb(1'b1, `OFS_CTRL0, 32'h19);
      wt(20);
      h0 = hic;
      wt(PWN[k]);
      `CHK("pwm_high", PHI[k], hic - h0)
      apb(1'b0, `OFS_FLAGS, 32'h0);
      `CHK("pwm_flags", PFL[k], rdv[1:0])
    end
    // Count rate for each clock selection over 512 system cycles
    apb(1'b1, `OFS_CTRL0, 32'h10);
    apb(1'b1, `OFS_CTRL1, 32'h00);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, `OFS_CTRL0, {24'h0, 1'b0, s[2:0], 4'h8});
      apb(1'b0, `OFS_COUNT, 32'h0);
      c1 = rdv[9:0];
      wt(509);
      apb(1'b0, `OFS_COUNT, 32'h0);
      `CHK("clock_rate", CKX[s], rdv[9:0] - c1)
    end
    `CHK("pin_pair", 1'b1, pair_ok)
    give_verdict();
  end
endmodule
